// ---- hdl/spi_seq_pkg.sv ----
// shared constants and types of the select and command sequencer
package spi_seq_pkg;
	localparam int CMD_NUM = 8;
	localparam int CMD_IDX_W = 3;
	localparam int SEL_NUM = 4;
	localparam int DATA_W = 32;
	localparam int LEN_W = 5;
	localparam int RATE_W = 8;
	localparam int DLY_W = 3;
	localparam int BIT_CNT_W = 6;
	localparam int TICK_CNT_W = 4;
	localparam int BUF_DEPTH = 2;
	localparam int SYNC_W = 4;
	localparam int SYNC_SCLK = 0;
	localparam int SYNC_SEL = 1;
	localparam int SYNC_MOSI = 2;
	localparam int SYNC_MISO = 3;
	localparam logic [CMD_IDX_W-1:0] CMD_FIRST = 3'h0;
	localparam logic [SEL_NUM-1:0] SEL_OE_SINGLE = 4'hf;
	localparam logic [SEL_NUM-1:0] SEL_OE_MULTI = 4'he;
	localparam logic [SEL_NUM-1:0] SEL_OE_SLAVE = 4'h0;
	typedef enum logic [1:0] {
		MODE_SINGLE = 2'h0,
		MODE_MULTI = 2'h1,
		MODE_SLAVE = 2'h2
	} op_mode_e;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_LEAD = 3'h1,
		ST_SHIFT = 3'h3,
		ST_TRAIL = 3'h2,
		ST_NEXT = 3'h6
	} seq_state_e;
endpackage

// ---- hdl/pin_sync.sv ----
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 4
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// pins
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] pin_sync_out
);
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			logic meta_reg;
			logic stable_reg;
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					meta_reg <= 1'b0;
					stable_reg <= 1'b0;
				end else begin
					meta_reg <= pin_in[i];
					stable_reg <= meta_reg;
				end
			end
			assign pin_sync_out[i] = stable_reg;
		end
	endgenerate
endmodule // pin_sync

// ---- hdl/two_entry_buffer.sv ----
// small buffer with valid and ready on both sides
`timescale 1ns/1ps
module two_entry_buffer #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 2
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// filling side
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	// draining side
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CNT_W = $clog2(DEPTH + 1);
	localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
	localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [PTR_W-1:0] wr_reg, wr_next, rd_reg, rd_next;
	logic [CNT_W-1:0] cnt_reg, cnt_next;
	logic push, pop;

	assign in_ready = (cnt_reg != FULL_CNT);
	assign out_valid = (cnt_reg != '0);
	assign out_data = mem_reg[rd_reg];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		wr_next = push ? ((wr_reg == LAST_PTR) ? '0 : wr_reg + 1'b1) : wr_reg;
		rd_next = pop ? ((rd_reg == LAST_PTR) ? '0 : rd_reg + 1'b1) : rd_reg;
		cnt_next = cnt_reg + CNT_W'(push) - CNT_W'(pop);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
		end else begin
			wr_reg <= wr_next;
			rd_reg <= rd_next;
			cnt_reg <= cnt_next;
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			mem_reg[wr_reg] <= in_data;
		end
	end
endmodule // two_entry_buffer

// ---- hdl/spi_select_and_command_sequencer.sv ----
// serial channel with select control and looped command sequencing
`timescale 1ns/1ps
module spi_select_and_command_sequencer (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// configuration
	input wire spi_seq_pkg::op_mode_e op_mode,
	input wire logic select_active_high,
	input wire logic idle_data_level,
	input wire logic clock_autostop_enable,
	input wire logic parity_enable,
	input wire logic parity_odd,
	input wire logic [spi_seq_pkg::CMD_IDX_W-1:0] seq_last,
	// command table
	input wire logic [spi_seq_pkg::CMD_NUM-1:0][spi_seq_pkg::SEL_NUM-1:0] cmd_select,
	input wire logic [spi_seq_pkg::CMD_NUM-1:0][spi_seq_pkg::RATE_W-1:0] cmd_rate,
	input wire logic [spi_seq_pkg::CMD_NUM-1:0] cmd_cpol,
	input wire logic [spi_seq_pkg::CMD_NUM-1:0] cmd_cpha,
	input wire logic [spi_seq_pkg::CMD_NUM-1:0][spi_seq_pkg::LEN_W-1:0] cmd_len,
	input wire logic [spi_seq_pkg::CMD_NUM-1:0] cmd_lsb_first,
	input wire logic [spi_seq_pkg::CMD_NUM-1:0] cmd_burst,
	input wire logic [spi_seq_pkg::CMD_NUM-1:0][spi_seq_pkg::DLY_W-1:0] cmd_clk_delay,
	input wire logic [spi_seq_pkg::CMD_NUM-1:0][spi_seq_pkg::DLY_W-1:0] cmd_neg_delay,
	input wire logic [spi_seq_pkg::CMD_NUM-1:0][spi_seq_pkg::DLY_W-1:0] cmd_next_delay,
	// transmit stream
	input wire logic [spi_seq_pkg::DATA_W-1:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready,
	// receive stream
	output logic [spi_seq_pkg::DATA_W-1:0] rx_data,
	output logic rx_valid,
	input wire logic rx_ready,
	// status and flag clears
	output logic mode_fault_flag,
	output logic underrun_flag,
	output logic overrun_flag,
	output logic parity_error_flag,
	output logic idle,
	output logic [spi_seq_pkg::CMD_IDX_W-1:0] cmd_index,
	input wire logic clear_mode_fault,
	input wire logic clear_underrun,
	input wire logic clear_overrun,
	input wire logic clear_parity_error,
	// interrupt enables and requests
	input wire logic rx_irq_enable,
	input wire logic tx_irq_enable,
	input wire logic error_irq_enable,
	input wire logic idle_irq_enable,
	output logic rx_full_irq,
	output logic tx_empty_irq,
	output logic error_irq,
	output logic idle_irq,
	// select pins
	input wire logic [spi_seq_pkg::SEL_NUM-1:0] select_pin_in,
	output logic [spi_seq_pkg::SEL_NUM-1:0] select_pin_out,
	output logic [spi_seq_pkg::SEL_NUM-1:0] select_pin_oe,
	// serial clock pin
	input wire logic serial_clock_pin_in,
	output logic serial_clock_pin_out,
	output logic serial_clock_pin_oe,
	// data pins
	input wire logic mosi_in,
	output logic mosi_out,
	output logic mosi_oe,
	input wire logic miso_in,
	output logic miso_out,
	output logic miso_oe
);
	import spi_seq_pkg::*;

	// ****************************************
	// reset release and pin synchronisers
	// ****************************************
	logic rst_meta_reg, rst_sync_n_reg;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_reg <= 1'b0;
			rst_sync_n_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_n_reg <= rst_meta_reg;
		end
	end

	logic [SYNC_W-1:0] pins_s;
	pin_sync #(.WIDTH(SYNC_W)) u_pin_sync (
		.clk(clk),
		.rst_n(rst_sync_n_reg),
		.pin_in({miso_in, mosi_in, (select_pin_in[0] == select_active_high), serial_clock_pin_in}),
		.pin_sync_out(pins_s)
	);

	// ****************************************
	// buffers
	// ****************************************
	logic [DATA_W-1:0] txb_data, rxb_data;
	logic txb_valid, txb_pop, rxb_push, rxb_ready;
	two_entry_buffer #(.WIDTH(DATA_W), .DEPTH(BUF_DEPTH)) u_tx_buf (
		.clk(clk),
		.rst_n(rst_sync_n_reg),
		.in_data(tx_data),
		.in_valid(tx_valid),
		.in_ready(tx_ready),
		.out_data(txb_data),
		.out_valid(txb_valid),
		.out_ready(txb_pop)
	);
	two_entry_buffer #(.WIDTH(DATA_W), .DEPTH(BUF_DEPTH)) u_rx_buf (
		.clk(clk),
		.rst_n(rst_sync_n_reg),
		.in_data(rxb_data),
		.in_valid(rxb_push),
		.in_ready(rxb_ready),
		.out_data(rx_data),
		.out_valid(rx_valid),
		.out_ready(rx_ready)
	);

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [DATA_W-1:0] reverse_word(input logic [DATA_W-1:0] d);
		logic [DATA_W-1:0] r;
		r = '0;
		for (int i = 0; i < DATA_W; i++) begin
			r[DATA_W-1-i] = d[i];
		end
		return r;
	endfunction

	function automatic logic [DATA_W-1:0] len_mask(input logic [LEN_W-1:0] len);
		return {DATA_W{1'b1}} >> (LEN_W'(DATA_W - 1) - len);
	endfunction

	// ****************************************
	// state
	// ****************************************
	seq_state_e state_reg, state_next;
	logic [CMD_IDX_W-1:0] idx_reg, idx_next;
	logic [RATE_W-1:0] div_reg, div_next;
	logic [TICK_CNT_W-1:0] dly_reg, dly_next;
	logic [BIT_CNT_W-1:0] bit_reg, bit_next;
	logic phase_reg, phase_next;
	logic [DATA_W-1:0] txsh_reg, txsh_next, rxsh_reg, rxsh_next;
	logic txpar_reg, txpar_next, rxpar_reg, rxpar_next;
	logic sclk_reg, sclk_next, sel_act_reg, sel_act_next;
	logic sclk_prev_reg, sel_prev_reg;
	logic mode_fault_flag_reg, udr_reg, ovr_reg, par_reg;
	logic set_mode_fault_flag, set_udr, set_ovr, set_par;

	// ****************************************
	// current and following command
	// ****************************************
	logic [CMD_IDX_W-1:0] idx_wrap;
	logic c_cpol, c_cpha, c_lsb, n_lsb;
	logic [LEN_W-1:0] c_len, n_len;
	logic [BIT_CNT_W-1:0] last_bit;
	logic is_master, tick, lead_ev, trail_ev, sample, frame_end, stall;
	logic sel_in_act, slave_sel, mm_fault, sdi;
	logic [DATA_W-1:0] rx_word, rx_shift;
	logic rx_par_bit;

	assign idx_wrap = (idx_reg == seq_last) ? CMD_FIRST : idx_reg + 1'b1;
	assign c_cpol = cmd_cpol[idx_reg];
	assign c_cpha = cmd_cpha[idx_reg];
	assign c_len = cmd_len[idx_reg];
	assign c_lsb = cmd_lsb_first[idx_reg];
	assign n_len = cmd_len[idx_wrap];
	assign n_lsb = cmd_lsb_first[idx_wrap];
	assign last_bit = BIT_CNT_W'(c_len) + BIT_CNT_W'(parity_enable);
	assign is_master = (op_mode != MODE_SLAVE);
	assign sel_in_act = pins_s[SYNC_SEL];
	assign mm_fault = (op_mode == MODE_MULTI) && sel_in_act;
	assign slave_sel = (op_mode == MODE_SLAVE) && sel_in_act;
	assign sdi = is_master ? pins_s[SYNC_MISO] : pins_s[SYNC_MOSI];

	assign stall = clock_autostop_enable && is_master && (state_reg == ST_SHIFT) && phase_reg
		&& (bit_reg == last_bit) && !rxb_ready;
	assign tick = (div_reg == cmd_rate[idx_reg]) && !stall;

	always_comb begin
		if (is_master) begin
			lead_ev = (state_reg == ST_SHIFT) && tick && !phase_reg;
			trail_ev = (state_reg == ST_SHIFT) && tick && phase_reg;
		end else begin
			lead_ev = slave_sel && (pins_s[SYNC_SCLK] != sclk_prev_reg)
				&& (pins_s[SYNC_SCLK] != c_cpol);
			trail_ev = slave_sel && (pins_s[SYNC_SCLK] != sclk_prev_reg)
				&& (pins_s[SYNC_SCLK] == c_cpol);
		end
	end

	// sampling, received word assembly and parity bit capture
	always_comb begin
		sample = c_cpha ? trail_ev : lead_ev;
		frame_end = trail_ev && (bit_reg == last_bit);
		rx_shift = rxsh_reg;
		rx_par_bit = rxpar_reg;
		if (sample && bit_reg <= BIT_CNT_W'(c_len)) begin
			rx_shift = {rxsh_reg[DATA_W-2:0], sdi};
		end else if (sample) begin
			rx_par_bit = sdi;
		end
		if (c_lsb) begin
			rx_word = reverse_word(rx_shift) >> (LEN_W'(DATA_W - 1) - c_len);
		end else begin
			rx_word = rx_shift & len_mask(c_len);
		end
	end
	assign rxb_data = rx_word;

	// ****************************************
	// sequencer next state
	// ****************************************
	always_comb begin
		state_next = state_reg;
		idx_next = idx_reg;
		div_next = (div_reg == cmd_rate[idx_reg] || state_reg == ST_IDLE) ? '0 : div_reg + 1'b1;
		if (stall) begin
			div_next = div_reg;
		end
		dly_next = dly_reg;
		bit_next = bit_reg;
		phase_next = phase_reg;
		txsh_next = txsh_reg;
		txpar_next = txpar_reg;
		rxsh_next = rx_shift;
		rxpar_next = rx_par_bit;
		sclk_next = sclk_reg;
		sel_act_next = sel_act_reg;
		txb_pop = 1'b0;
		rxb_push = 1'b0;
		set_mode_fault_flag = 1'b0;
		set_udr = 1'b0;
		set_ovr = 1'b0;
		set_par = 1'b0;
		case (state_reg)
			ST_IDLE: begin
				sclk_next = c_cpol;
				sel_act_next = 1'b0;
				dly_next = '0;
				bit_next = '0;
				phase_next = 1'b0;
				if (is_master) begin
					if (mm_fault) begin
						set_mode_fault_flag = 1'b1;
					end else if (txb_valid && !mode_fault_flag_reg) begin
						txb_pop = 1'b1;
						sel_act_next = 1'b1;
						state_next = ST_LEAD;
					end
				end else if (slave_sel && !sel_prev_reg) begin
					txb_pop = txb_valid;
					set_udr = !txb_valid;
					state_next = ST_SHIFT;
				end
				if (txb_valid) begin
					txsh_next = c_lsb ? reverse_word(txb_data) : txb_data << (LEN_W'(DATA_W - 1) - c_len);
					txpar_next = (^(txb_data & len_mask(c_len))) ^ parity_odd;
				end else begin
					txsh_next = {DATA_W{idle_data_level}};
					txpar_next = idle_data_level;
				end
			end
			ST_LEAD: begin
				if (tick) begin
					dly_next = dly_reg + 1'b1;
					if (dly_reg == {cmd_clk_delay[idx_reg], 1'b1}) begin
						dly_next = '0;
						state_next = ST_SHIFT;
					end
				end
			end
			ST_SHIFT: begin
				if (is_master && tick) begin
					sclk_next = !sclk_reg;
					phase_next = !phase_reg;
				end
				if ((c_cpha ? lead_ev : trail_ev) && !(c_cpha && bit_reg == '0)) begin
					txsh_next = {txsh_reg[DATA_W-2:0], 1'b0};
				end
				if (trail_ev) begin
					bit_next = bit_reg + 1'b1;
				end
				if (frame_end) begin
					bit_next = '0;
					if (rxb_ready) begin
						rxb_push = 1'b1;
					end else begin
						set_ovr = 1'b1;
					end
					set_par = parity_enable && ((^(rx_word)) ^ rx_par_bit ^ parity_odd);
					if (is_master && cmd_burst[idx_reg] && txb_valid) begin
						txb_pop = 1'b1;
						idx_next = idx_wrap;
						txsh_next = n_lsb ? reverse_word(txb_data) : txb_data << (LEN_W'(DATA_W - 1) - n_len);
						txpar_next = (^(txb_data & len_mask(n_len))) ^ parity_odd;
					end else if (is_master) begin
						state_next = ST_TRAIL;
					end else begin
						txb_pop = txb_valid;
						set_udr = !txb_valid;
						txsh_next = c_lsb ? reverse_word(txb_data) : txb_data << (LEN_W'(DATA_W - 1) - c_len);
						txpar_next = (^(txb_data & len_mask(c_len))) ^ parity_odd;
					end
				end
				if (!is_master && !slave_sel) begin
					set_mode_fault_flag = (bit_reg != '0) || phase_reg;
					state_next = ST_IDLE;
				end
			end
			ST_TRAIL: begin
				if (tick) begin
					dly_next = dly_reg + 1'b1;
					if (dly_reg == {cmd_neg_delay[idx_reg], 1'b1}) begin
						dly_next = '0;
						sel_act_next = 1'b0;
						state_next = ST_NEXT;
					end
				end
			end
			ST_NEXT: begin
				if (tick) begin
					dly_next = dly_reg + 1'b1;
					if (dly_reg == {cmd_next_delay[idx_reg], 1'b1}) begin
						idx_next = idx_wrap;
						state_next = ST_IDLE;
					end
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
		if (mm_fault && state_reg != ST_IDLE) begin
			set_mode_fault_flag = 1'b1;
			sel_act_next = 1'b0;
			state_next = ST_IDLE;
		end
		if (!is_master) begin
			idx_next = CMD_FIRST;
		end
	end

	always_ff @(posedge clk or negedge rst_sync_n_reg) begin
		if (!rst_sync_n_reg) begin
			state_reg <= ST_IDLE;
			idx_reg <= CMD_FIRST;
			div_reg <= '0;
			dly_reg <= '0;
			bit_reg <= '0;
			phase_reg <= 1'b0;
			txsh_reg <= '0;
			txpar_reg <= 1'b0;
			rxsh_reg <= '0;
			rxpar_reg <= 1'b0;
			sclk_reg <= 1'b0;
			sel_act_reg <= 1'b0;
			sclk_prev_reg <= 1'b0;
			sel_prev_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			idx_reg <= idx_next;
			div_reg <= div_next;
			dly_reg <= dly_next;
			bit_reg <= bit_next;
			phase_reg <= phase_next;
			txsh_reg <= txsh_next;
			txpar_reg <= txpar_next;
			rxsh_reg <= rxsh_next;
			rxpar_reg <= rxpar_next;
			sclk_reg <= sclk_next;
			sel_act_reg <= sel_act_next;
			sclk_prev_reg <= pins_s[SYNC_SCLK];
			sel_prev_reg <= slave_sel;
		end
	end

	// ****************************************
	// error flags, set wins over clear
	// ****************************************
	logic mode_fault_flag_next, udr_next, ovr_next, par_next;
	always_comb begin
		mode_fault_flag_next = (mode_fault_flag_reg && !clear_mode_fault) || set_mode_fault_flag || set_udr;
		udr_next = (udr_reg && !clear_underrun) || set_udr;
		ovr_next = (ovr_reg && !clear_overrun) || set_ovr;
		par_next = (par_reg && !clear_parity_error) || set_par;
	end

	always_ff @(posedge clk or negedge rst_sync_n_reg) begin
		if (!rst_sync_n_reg) begin
			mode_fault_flag_reg <= 1'b0;
			udr_reg <= 1'b0;
			ovr_reg <= 1'b0;
			par_reg <= 1'b0;
		end else begin
			mode_fault_flag_reg <= mode_fault_flag_next;
			udr_reg <= udr_next;
			ovr_reg <= ovr_next;
			par_reg <= par_next;
		end
	end

	// ****************************************
	// status, interrupts and pins
	// ****************************************
	assign mode_fault_flag = mode_fault_flag_reg;
	assign underrun_flag = udr_reg;
	assign overrun_flag = ovr_reg;
	assign parity_error_flag = par_reg;
	assign cmd_index = idx_reg;
	assign idle = (state_reg == ST_IDLE) && !txb_valid && !slave_sel;
	assign rx_full_irq = rx_irq_enable && rx_valid;
	assign tx_empty_irq = tx_irq_enable && tx_ready;
	assign error_irq = error_irq_enable && (mode_fault_flag_reg || udr_reg || ovr_reg || par_reg);
	assign idle_irq = idle_irq_enable && idle;

	always_comb begin
		case (op_mode)
			MODE_SINGLE: select_pin_oe = SEL_OE_SINGLE;
			MODE_MULTI: select_pin_oe = SEL_OE_MULTI;
			default: select_pin_oe = SEL_OE_SLAVE;
		endcase
		for (int i = 0; i < SEL_NUM; i++) begin
			select_pin_out[i] = (sel_act_reg && cmd_select[idx_reg][i]) ? select_active_high
				: !select_active_high;
		end
	end

	assign serial_clock_pin_out = sclk_reg;
	assign serial_clock_pin_oe = is_master;
	assign mosi_out = !sel_act_reg ? idle_data_level
		: (bit_reg > BIT_CNT_W'(c_len)) ? txpar_reg : txsh_reg[DATA_W-1];
	assign mosi_oe = is_master;
	assign miso_out = (bit_reg > BIT_CNT_W'(c_len)) ? txpar_reg : txsh_reg[DATA_W-1];
	assign miso_oe = slave_sel;
endmodule // spi_select_and_command_sequencer

// ---- tb/spi_seq_chk.sv ----
// concurrent checks on the sequencer's ports
`timescale 1ns/1ps
module spi_seq_chk
	import spi_seq_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// configuration
	input wire spi_seq_pkg::op_mode_e op_mode,
	input wire logic select_active_high,
	input wire logic idle_data_level,
	input wire logic clock_autostop_enable,
	// status
	input wire logic rx_valid,
	input wire logic mode_fault_flag,
	input wire logic underrun_flag,
	input wire logic overrun_flag,
	input wire logic parity_error_flag,
	input wire logic idle,
	// interrupts
	input wire logic rx_irq_enable,
	input wire logic error_irq_enable,
	input wire logic idle_irq_enable,
	input wire logic rx_full_irq,
	input wire logic error_irq,
	input wire logic idle_irq,
	// pins
	input wire logic [spi_seq_pkg::SEL_NUM-1:0] select_pin_out,
	input wire logic [spi_seq_pkg::SEL_NUM-1:0] select_pin_oe,
	input wire logic serial_clock_pin_oe,
	input wire logic mosi_out,
	input wire logic mosi_oe
);
	// ****************
	// properties
	// ****************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	logic neg;
	assign neg = select_pin_out == {4{!select_active_high}};
	chk_oe_single: assert property ($stable(op_mode) && op_mode == MODE_SINGLE |->
		select_pin_oe == SEL_OE_SINGLE && serial_clock_pin_oe) else $error("single oe wrong");
	chk_oe_multi: assert property ($stable(op_mode) && op_mode == MODE_MULTI |->
		select_pin_oe == SEL_OE_MULTI) else $error("multi oe wrong");
	chk_oe_slave: assert property ($stable(op_mode) && op_mode == MODE_SLAVE |->
		select_pin_oe == SEL_OE_SLAVE && !serial_clock_pin_oe) else $error("slave oe wrong");
	chk_sel_idle: assert property (op_mode == MODE_SINGLE && idle |-> neg)
		else $error("select not negated when idle");
	chk_mosi_idle: assert property (mosi_oe && neg && $past(neg) |->
		mosi_out == idle_data_level) else $error("mosi not at idle level");
	chk_rx_irq: assert property (rx_irq_enable && $rose(rx_valid) |-> rx_full_irq)
		else $error("no receive irq");
	chk_err_irq: assert property (error_irq == (error_irq_enable && (mode_fault_flag
		|| overrun_flag || underrun_flag || parity_error_flag))) else $error("error irq wrong");
	chk_idle_irq: assert property (idle_irq == (idle_irq_enable && idle))
		else $error("idle irq wrong");
	chk_no_overrun: assert property (clock_autostop_enable && op_mode == MODE_SINGLE
		|-> !$rose(overrun_flag)) else $error("overrun despite autostop");
	chk_udr_mode_fault_flag: assert property ($rose(underrun_flag) |-> mode_fault_flag)
		else $error("underrun without mode fault");
	cover property ($rose(rx_full_irq));
	cover property ($rose(mode_fault_flag));
	cover property ($rose(underrun_flag));
endmodule // spi_seq_chk

bind spi_select_and_command_sequencer spi_seq_chk u_chk (.*);

// ---- tb/spi_slave_model.sv ----
// external slave on the master side: mode 0 reply and capture
`timescale 1ns/1ps
module spi_slave_model #(
	parameter logic [31:0] REPLY = 32'hc3a5_0f96
) (
	// pins
	input wire logic sclk,
	input wire logic sel_n,
	input wire logic mosi,
	output logic miso
);
	// ****************
	// shifting
	// ****************
	logic [31:0] sh = 32'h0;
	logic [31:0] cap = 32'h0;
	logic [31:0] got [8];
	int k = -1;
	initial miso = 1'h0;
	always @(negedge sel_n) begin
		k = k + 1;
		sh = REPLY;
		cap = 32'h0;
		miso = sh[31];
	end
	// released line shows the inverse of its last bit
	always @(posedge sel_n) begin
		if (k >= 0) got[k] = cap;
		miso = ~miso;
	end
	always @(posedge sclk) if (!sel_n) cap = {cap[30:0], mosi};
	always @(negedge sclk) begin
		if (!sel_n) begin
			sh = {sh[30:0], 1'h0};
			miso = sh[31];
		end
	end
endmodule // spi_slave_model

// ---- tb/tb.sv ----
// bench: reset, scenarios, verdict
`timescale 1ns/1ps
module tb;
	import spi_seq_pkg::*;
	// ****************
	// signals
	// ****************
	localparam logic [31:0] REPLY = 32'hc3a5_0f96;
	logic clk = 1'h0, rst_n = 1'h0, select_active_high = 1'h0, idle_data_level = 1'h1;
	logic clock_autostop_enable = 1'h1, parity_enable = 1'h0, parity_odd = 1'h0;
	op_mode_e op_mode = MODE_SINGLE;
	logic [2:0] seq_last = 3'h2, cmd_index;
	logic [7:0][3:0] cmd_select = {20'h0, 4'h5, 4'h3, 4'h1};
	logic [7:0][7:0] cmd_rate = {40'h0, 8'h03, 8'h02, 8'h03};
	logic [7:0][4:0] cmd_len = {25'h0, 5'h1f, 5'h0b, 5'h07};
	logic [7:0] cmd_cpol = 8'h0, cmd_cpha = 8'h0, cmd_lsb_first = 8'h02, cmd_burst = 8'h0;
	logic [7:0][2:0] cmd_clk_delay = {15'h0, 3'h7, 3'h3, 3'h0};
	logic [7:0][2:0] cmd_neg_delay = {15'h0, 3'h7, 3'h0, 3'h2};
	logic [7:0][2:0] cmd_next_delay = {15'h0, 3'h7, 3'h4, 3'h1};
	logic [31:0] tx_data = 32'h0, rx_data;
	logic tx_valid = 1'h0, tx_ready, rx_valid, rx_ready = 1'h1;
	logic mode_fault_flag, underrun_flag, overrun_flag, parity_error_flag, idle;
	logic clear_mode_fault = 1'h0, clear_underrun = 1'h0;
	logic clear_overrun = 1'h0, clear_parity_error = 1'h0;
	logic rx_irq_enable = 1'h1, tx_irq_enable = 1'h1, error_irq_enable = 1'h1;
	logic idle_irq_enable = 1'h1, rx_full_irq, tx_empty_irq, error_irq, idle_irq;
	logic [3:0] select_pin_in = 4'hf, select_pin_out, select_pin_oe;
	logic serial_clock_pin_in = 1'h0, serial_clock_pin_out, serial_clock_pin_oe;
	logic mosi_in = 1'h0, mosi_out, mosi_oe, miso_in, miso_out, miso_oe;
	int fail_count = 0, cmp_count = 0, f = 0, nr = 0, cyc = 0, t_sel, t_last, t_neg;
	int lead[8], trail[8], gap[8];
	logic [2:0] idx[8];
	logic [3:0] pat[8];
	logic [31:0] rxw[8];
	logic sel_q = 1'h0, sck_q = 1'h0, first = 1'h0, saw_full = 1'h0;
	wire sel_on = select_pin_out != 4'hf;

	spi_select_and_command_sequencer u_dut (.*);
	spi_slave_model #(.REPLY(REPLY)) u_part (.sclk(serial_clock_pin_out),
		.sel_n(select_pin_out[0]), .mosi(mosi_out), .miso(miso_in));

	always #2.5 clk = ~clk;
	// ****************
	// frame monitor
	// ****************
	always @(posedge clk) begin
		if (rx_valid === 1'h1 && rx_ready) begin
			rxw[nr] = rx_data;
			nr++;
		end
		if (op_mode == MODE_SINGLE) begin
			cyc++;
			if (sel_on && !sel_q) begin
				if (f > 0) gap[f] = cyc - t_neg;
				t_sel = cyc;
				idx[f] = cmd_index;
				pat[f] = select_pin_out;
				first = 1'h1;
			end
			if (sel_on && serial_clock_pin_out !== sck_q) begin
				if (first) lead[f] = cyc - t_sel;
				first = 1'h0;
				t_last = cyc;
			end
			if (!sel_on && sel_q) begin
				trail[f] = cyc - t_last;
				t_neg = cyc;
				f++;
			end
			sel_q = sel_on;
			sck_q = serial_clock_pin_out;
		end
	end
	// ****************
	// tasks
	// ****************
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic tmo();
		fail_count++;
		$display("ERROR %0t: wait ran out", $time);
		final_report();
	endtask
	function automatic logic [31:0] pick(input logic [31:0] v, input int len, input logic lsb);
		logic [31:0] r;
		r = 32'h0;
		for (int i = 0; i <= len; i++) r[i] = lsb ? v[len - i] : v[i];
		return r;
	endfunction
	function automatic logic [31:0] win(input int m, input int e, input int r);
		return (m >= e - r && m <= e + r + 2) ? 32'h1 : 32'h0;
	endfunction
	task automatic send(input logic [31:0] d);
		int i;
		tx_data <= d;
		tx_valid <= 1'h1;
		for (i = 0; i < 5000; i++) begin
			@(posedge clk);
			if (tx_ready !== 1'h1) saw_full = 1'h1;
			else break;
		end
		if (i == 5000) tmo();
	endtask
	task automatic wait_f(input int n);
		for (int i = 0; i < 20000 && f < n; i++) @(posedge clk);
		if (f < n) tmo();
	endtask
	task automatic clear_all();
		{clear_mode_fault, clear_underrun, clear_overrun, clear_parity_error} <= 4'hf;
		@(posedge clk);
		{clear_mode_fault, clear_underrun, clear_overrun, clear_parity_error} <= 4'h0;
		repeat (2) @(posedge clk);
	endtask
	task automatic slv(input logic [7:0] m, output logic [7:0] s);
		select_pin_in <= 4'he;
		repeat (16) @(posedge clk);
		check(miso_oe, 1);
		for (int i = 7; i >= 0; i--) begin
			mosi_in <= m[i];
			repeat (8) @(posedge clk);
			s[i] = miso_out;
			serial_clock_pin_in <= 1'h1;
			repeat (8) @(posedge clk);
			serial_clock_pin_in <= 1'h0;
		end
		repeat (16) @(posedge clk);
		select_pin_in <= 4'hf;
		mosi_in <= ~m[0];
		repeat (16) @(posedge clk);
	endtask
	// ****************
	// scenarios
	// ****************
	task automatic t_master();
		logic [31:0] w [4];
		int c, r, p;
		w = '{32'h0000_00a5, 32'h0000_0c3f, 32'h1234_5678, 32'h0000_005a};
		repeat (200) @(posedge clk);
		check(f, 0);
		check(idle_irq, 1);
		check(tx_empty_irq, 1);
		rx_ready <= 1'h0;
		foreach (w[i]) send(w[i]);
		tx_valid <= 1'h0;
		check(saw_full, 1);
		wait_f(2);
		repeat (1000) @(posedge clk);
		check(f, 2);
		check(overrun_flag, 0);
		rx_ready <= 1'h1;
		wait_f(4);
		repeat (20) @(posedge clk);
		for (int i = 0; i < 4; i++) begin
			c = i % 3;
			r = cmd_rate[c] + 1;
			p = cmd_rate[(i + 2) % 3] + 1;
			check(idx[i], c);
			check(pat[i], 4'(~cmd_select[c]));
			check(u_part.got[i], pick(w[i], cmd_len[c], cmd_lsb_first[c]));
			check(rxw[i], pick(REPLY >> (31 - cmd_len[c]), cmd_len[c], cmd_lsb_first[c]));
			check(win(lead[i], (cmd_clk_delay[c] + 1) * 2 * r, r), 1);
			check(win(trail[i], (cmd_neg_delay[c] + 1) * 2 * r, r), 1);
			if (i > 0) check(win(gap[i], (cmd_next_delay[(i + 2) % 3] + 1) * 2 * p, p), 1);
		end
		$display("test master done");
	endtask
	task automatic t_slave();
		logic [7:0] s;
		op_mode <= MODE_SLAVE;
		send(32'h0000_003c);
		tx_valid <= 1'h0;
		slv(8'h96, s);
		check(s, 8'h3c);
		check(rxw[4], 32'h96);
		slv(8'h55, s);
		check(miso_oe, 0);
		check(underrun_flag, 1);
		check(mode_fault_flag, 1);
		clear_underrun <= 1'h1;
		@(posedge clk);
		clear_underrun <= 1'h0;
		repeat (2) @(posedge clk);
		check(underrun_flag, 0);
		check(mode_fault_flag, 1);
		clear_all();
		check(mode_fault_flag, 0);
		$display("test slave done");
	endtask
	task automatic t_multi();
		op_mode <= MODE_MULTI;
		select_active_high <= 1'h1;
		select_pin_in <= 4'h0;
		repeat (4) @(posedge clk);
		check(select_pin_out, 4'h0);
		check(mode_fault_flag, 0);
		select_pin_in <= 4'h1;
		repeat (8) @(posedge clk);
		check(mode_fault_flag, 1);
		check(error_irq, 1);
		select_pin_in <= 4'h0;
		repeat (4) @(posedge clk);
		clear_all();
		check(error_irq, 0);
		$display("test multi done");
	endtask
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'h1;
		t_master();
		t_slave();
		t_multi();
		final_report();
	end
endmodule // tb
